// ### design/t8woc_pkg.sv
// Purpose: Types shared by the waveform output control.
// Assumes: Nothing beyond SystemVerilog packages.
// Notes:   Numeric offsets live in t8woc_regs.svh.
package t8woc_pkg;

  // Register port request from software
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } t8woc_req_t;

  // Count sequence class decoded from the three mode bits
  typedef enum logic [2:0] {
    T8WOC_CLS_NORMAL = 3'b000,
    T8WOC_CLS_PHASE = 3'b001,
    T8WOC_CLS_CTC = 3'b010,
    T8WOC_CLS_FAST = 3'b011,
    T8WOC_CLS_RSVD = 3'b100
  } t8woc_cls_t;

  // Sticky event flags
  typedef struct packed {
    logic match_b;
    logic match_a;
    logic ovf;
  } t8woc_flags_t;

endpackage

// ### design/t8woc_regs.svh
// Purpose: Register offsets, field positions and fixed values of the waveform output control.
// Assumes: Byte-wide register port with an 8-bit address.
// Notes:   Definitions only; included by bare name.
`ifndef T8WOC_REGS_SVH
`define T8WOC_REGS_SVH

// Register offsets
`define T8WOC_OFS_CTRL_A    8'h24
`define T8WOC_OFS_CTRL_B    8'h25
`define T8WOC_OFS_COUNT     8'h26
`define T8WOC_OFS_CMP_A     8'h27
`define T8WOC_OFS_CMP_B     8'h28
`define T8WOC_OFS_FLAGS     8'h35

// Control A field positions
`define T8WOC_COM_A_HI      7
`define T8WOC_COM_A_LO      6
`define T8WOC_COM_B_HI      5
`define T8WOC_COM_B_LO      4
`define T8WOC_WGM_LOW_HI    1
`define T8WOC_WGM_LOW_LO    0

// Control B field position of the mode high bit
`define T8WOC_WGM_HIGH_BIT  3

// Flag register field positions
`define T8WOC_FLAG_OVF      0
`define T8WOC_FLAG_A        1
`define T8WOC_FLAG_B        2

// Fixed values
`define T8WOC_RESET_BYTE    8'h00
`define T8WOC_MAX           8'hFF
`define T8WOC_BOTTOM        8'h00
`define T8WOC_ONE           8'h01

`endif

// ### design/t8woc_top.sv
// What this block does
// - Counter synchronous; tick is only enable
// - Nonzero output mode overrides pin function, reserved selections excepted
// - Channel A non-PWM: off/toggle/clear/set
// - Channel A fast PWM modes incl toggle
// - Channel A phase correct modes incl toggle
// - Fast PWM A compare at TOP: bottom action
// - Phase PWM A compare at TOP: top action
// - Channel B non-PWM: off/toggle/clear/set
// - Channel B fast PWM; mode one reserved
// - Channel B phase PWM; mode one reserved
// - Channel B compare at TOP special case
// - Control bits three, two read zero
// - Three mode bits select count sequence
// - Mode encodings and TOP sources
// - Compare update immediate or buffered
// - Overflow flag timing per mode
// - Compare flags set on match
// - Compare A TOP match clears counter in CTC and fast PWM
// - Flags cleared by ack or one
// - Fast PWM counts to TOP, then clears
// - Phase PWM turns at TOP, one tick
//
// Purpose: 8-bit timer with two compare channels and waveform outputs.
// Assumes: SYS_CLK is the I/O clock; TICK_EN comes from a prescaler on the same clock.
// Notes:   Read data appear in the cycle after the read strobe.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ns
`include "t8woc_regs.svh"

module t8woc_top
  import t8woc_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire t8woc_req_t REG_REQ,
  output logic [7:0] REG_RDATA,
  input wire logic TICK_EN,
  input wire logic ACK_OVF,
  input wire logic ACK_A,
  input wire logic ACK_B,
  output logic CHAN_A_WAVE_OUT,
  output logic CHAN_A_OVERRIDE,
  output logic CHAN_B_WAVE_OUT,
  output logic CHAN_B_OVERRIDE,
  output t8woc_flags_t FLAGS,
  output logic [7:0] COUNT_VALUE
);

  // Next waveform level of one channel for the current cycle
  function automatic logic wave_next(
    input logic [1:0] com,
    input t8woc_cls_t cls,
    input logic tog_ok,
    input logic match,
    input logic ocr_top,
    input logic bot_evt,
    input logic top_evt,
    input logic eff_up,
    input logic cur
  );
    logic nxt;
    nxt = cur;
    case (cls)
      // Non-PWM: toggle, clear or set on a match
      T8WOC_CLS_NORMAL, T8WOC_CLS_CTC:
      begin
        if (match)
        begin
          case (com)
            2'b01: nxt = ~cur;
            2'b10: nxt = 1'b0;
            2'b11: nxt = 1'b1;
            default: nxt = cur;
          endcase
        end
      end
      // Single slope: match sets level, bottom restores it
      T8WOC_CLS_FAST:
      begin
        if (com == 2'b01)
        begin
          if (tog_ok && match)
            nxt = ~cur;
        end
        else if (com[1])
        begin
          if (match && !ocr_top)
            nxt = com[0];
          if (bot_evt)
            nxt = ~com[0];
        end
      end
      // Dual slope: direction chooses the level at a match
      T8WOC_CLS_PHASE:
      begin
        if (com == 2'b01)
        begin
          if (tog_ok && match)
            nxt = ~cur;
        end
        else if (com[1])
        begin
          if (match && !ocr_top)
            nxt = eff_up ? com[0] : ~com[0];
          if (top_evt && ocr_top)
            nxt = ~com[0];
        end
      end
      default: nxt = cur;
    endcase
    return nxt;
  endfunction

  // Software visible control fields
  logic [1:0] com_a_r;
  logic [1:0] com_b_r;
  logic [1:0] wgm_low_r;
  logic wgm_high_r;
  // Counter, direction and compare-block after a counter write
  logic [7:0] count_r;
  logic [7:0] count_nxt;
  logic up_r;
  logic up_nxt;
  logic block_r;
  // Compare buffers written by software and active copies
  logic [7:0] cmp_a_buf_r;
  logic [7:0] cmp_b_buf_r;
  logic [7:0] cmp_a_act_r;
  logic [7:0] cmp_b_act_r;
  // Output registers
  logic wave_a_r;
  logic wave_b_r;
  logic ovr_a_r;
  logic ovr_b_r;
  t8woc_flags_t flags_r;
  t8woc_flags_t flags_nxt;
  logic [7:0] rdata_r;

  // Register decode
  wire wr_ctrl_a = REG_REQ.wr && (REG_REQ.addr == `T8WOC_OFS_CTRL_A);
  wire wr_ctrl_b = REG_REQ.wr && (REG_REQ.addr == `T8WOC_OFS_CTRL_B);
  wire wr_count = REG_REQ.wr && (REG_REQ.addr == `T8WOC_OFS_COUNT);
  wire wr_cmp_a = REG_REQ.wr && (REG_REQ.addr == `T8WOC_OFS_CMP_A);
  wire wr_cmp_b = REG_REQ.wr && (REG_REQ.addr == `T8WOC_OFS_CMP_B);
  wire wr_flags = REG_REQ.wr && (REG_REQ.addr == `T8WOC_OFS_FLAGS);

  // Mode decode from the three mode bits
  // three mode bits
  wire [2:0] mode = {wgm_high_r, wgm_low_r};
  wire t8woc_cls_t cls = (mode == 3'd0) ? T8WOC_CLS_NORMAL :
                         (mode == 3'd1 || mode == 3'd5) ? T8WOC_CLS_PHASE :
                         (mode == 3'd2) ? T8WOC_CLS_CTC :
                         (mode == 3'd3 || mode == 3'd7) ? T8WOC_CLS_FAST :
                         T8WOC_CLS_RSVD;
  wire is_pwm = (cls == T8WOC_CLS_PHASE) || (cls == T8WOC_CLS_FAST);

  // Effective compare values
  // immediate or buffered
  wire [7:0] cmp_a_eff = is_pwm ? cmp_a_act_r : cmp_a_buf_r;
  wire [7:0] cmp_b_eff = is_pwm ? cmp_b_act_r : cmp_b_buf_r;

  // TOP value: fixed maximum or compare A
  // TOP source
  wire top_from_a = (mode == 3'd2) || (mode == 3'd5) || (mode == 3'd7);
  wire [7:0] top_v = top_from_a ? cmp_a_eff : `T8WOC_MAX;
  wire at_top = (count_r == top_v);
  wire at_bottom = (count_r == `T8WOC_BOTTOM);

  // Events qualified by the timer tick
  // enabled ticks only
  wire match_a = TICK_EN && !block_r && (count_r == cmp_a_eff);
  wire match_b = TICK_EN && !block_r && (count_r == cmp_b_eff);
  wire fast_bot_evt = TICK_EN && (cls == T8WOC_CLS_FAST) && at_top;
  wire pc_top_evt = TICK_EN && (cls == T8WOC_CLS_PHASE) && at_top;
  // Phase correct: bottom counts as up-counting
  wire eff_up = up_r || at_bottom;

  // Overflow event per mode
  // overflow timing
  wire ovf_evt = TICK_EN && (
      ((mode == 3'd0 || mode == 3'd2 || mode == 3'd3 || cls == T8WOC_CLS_RSVD)
        && (count_r == `T8WOC_MAX))
      || ((cls == T8WOC_CLS_PHASE) && at_bottom && !up_r)
      || ((mode == 3'd7) && at_top));

  // Pin override decode; reserved selections stay disconnected
  // pin override
  wire ovr_a_nxt = (com_a_r != 2'b00) && (cls != T8WOC_CLS_RSVD)
                   && !(is_pwm && (com_a_r == 2'b01) && !wgm_high_r);
  wire ovr_b_nxt = (com_b_r != 2'b00) && (cls != T8WOC_CLS_RSVD)
                   && !(is_pwm && (com_b_r == 2'b01));

  // Waveform next levels
  // A non-PWM actions
  wire wave_a_nxt = wave_next(com_a_r, cls, wgm_high_r, match_a, cmp_a_eff == top_v,
                              fast_bot_evt, pc_top_evt, eff_up, wave_a_r);
  wire wave_b_nxt = wave_next(com_b_r, cls, 1'b0, match_b, cmp_b_eff == top_v,
                              fast_bot_evt, pc_top_evt, eff_up, wave_b_r);

  // Read multiplexer
  // unused bits zero
  wire [7:0] rd_mux =
      (REG_REQ.addr == `T8WOC_OFS_CTRL_A) ? {com_a_r, com_b_r, 2'b00, wgm_low_r} :
      (REG_REQ.addr == `T8WOC_OFS_CTRL_B) ? {4'h0, wgm_high_r, 3'b000} :
      (REG_REQ.addr == `T8WOC_OFS_COUNT) ? count_r :
      (REG_REQ.addr == `T8WOC_OFS_CMP_A) ? cmp_a_buf_r :
      (REG_REQ.addr == `T8WOC_OFS_CMP_B) ? cmp_b_buf_r :
      (REG_REQ.addr == `T8WOC_OFS_FLAGS) ? {5'h00, flags_r} :
      8'h00;

  // Counter sequence for the current class
  // tick as enable
  always_comb
  begin
    count_nxt = count_r;
    up_nxt = up_r;
    if (TICK_EN)
    begin
      case (cls)
        T8WOC_CLS_CTC, T8WOC_CLS_FAST:
        begin
          count_nxt = at_top ? `T8WOC_BOTTOM : count_r + `T8WOC_ONE;
          up_nxt = 1'b1;
        end
        T8WOC_CLS_PHASE:
        begin
          if (up_r)
          begin
            count_nxt = at_top ? count_r - `T8WOC_ONE : count_r + `T8WOC_ONE;
            up_nxt = !at_top;
          end
          else
          begin
            count_nxt = at_bottom ? count_r + `T8WOC_ONE : count_r - `T8WOC_ONE;
            up_nxt = at_bottom;
          end
        end
        default:
        begin
          count_nxt = count_r + `T8WOC_ONE;
          up_nxt = 1'b1;
        end
      endcase
    end
    // Software write wins over the tick
    if (wr_count)
      count_nxt = REG_REQ.wdata;
  end

  // Flag update: hardware set wins over any clear
  // compare flags
  always_comb
  begin
    flags_nxt = flags_r;
    if (ACK_OVF || (wr_flags && REG_REQ.wdata[`T8WOC_FLAG_OVF]))
      flags_nxt.ovf = 1'b0;
    if (ACK_A || (wr_flags && REG_REQ.wdata[`T8WOC_FLAG_A]))
      flags_nxt.match_a = 1'b0;
    if (ACK_B || (wr_flags && REG_REQ.wdata[`T8WOC_FLAG_B]))
      flags_nxt.match_b = 1'b0;
    if (ovf_evt)
      flags_nxt.ovf = 1'b1;
    if (match_a)
      flags_nxt.match_a = 1'b1;
    if (match_b)
      flags_nxt.match_b = 1'b1;
  end

  // Control fields
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      com_a_r <= 2'b00;
      com_b_r <= 2'b00;
      wgm_low_r <= 2'b00;
      wgm_high_r <= 1'b0;
    end
    else
    begin
      if (wr_ctrl_a)
      begin
        com_a_r <= REG_REQ.wdata[`T8WOC_COM_A_HI:`T8WOC_COM_A_LO];
        com_b_r <= REG_REQ.wdata[`T8WOC_COM_B_HI:`T8WOC_COM_B_LO];
        wgm_low_r <= REG_REQ.wdata[`T8WOC_WGM_LOW_HI:`T8WOC_WGM_LOW_LO];
      end
      if (wr_ctrl_b)
        wgm_high_r <= REG_REQ.wdata[`T8WOC_WGM_HIGH_BIT];
    end
  end

  // Counter, direction and match blocking after a counter write
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      count_r <= `T8WOC_RESET_BYTE;
      up_r <= 1'b1;
      block_r <= 1'b0;
    end
    else
    begin
      count_r <= count_nxt;
      up_r <= up_nxt;
      // Block holds until the next tick
      block_r <= wr_count || (block_r && !TICK_EN);
    end
  end

  // Compare buffers and their active copies
  // update point
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      cmp_a_buf_r <= `T8WOC_RESET_BYTE;
      cmp_b_buf_r <= `T8WOC_RESET_BYTE;
      cmp_a_act_r <= `T8WOC_RESET_BYTE;
      cmp_b_act_r <= `T8WOC_RESET_BYTE;
    end
    else
    begin
      if (wr_cmp_a)
        cmp_a_buf_r <= REG_REQ.wdata;
      if (wr_cmp_b)
        cmp_b_buf_r <= REG_REQ.wdata;
      // Load at TOP (both PWM kinds turn or wrap there) or track buffer
      if (!is_pwm || (TICK_EN && at_top))
      begin
        cmp_a_act_r <= cmp_a_buf_r;
        cmp_b_act_r <= cmp_b_buf_r;
      end
    end
  end

  // Waveform levels, pin overrides and flags
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      wave_a_r <= 1'b0;
      wave_b_r <= 1'b0;
      ovr_a_r <= 1'b0;
      ovr_b_r <= 1'b0;
      flags_r <= '0;
    end
    else
    begin
      wave_a_r <= wave_a_nxt;
      wave_b_r <= wave_b_nxt;
      ovr_a_r <= ovr_a_nxt;
      ovr_b_r <= ovr_b_nxt;
      flags_r <= flags_nxt;
    end
  end

  // Read data register, valid only in the cycle after the strobe
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
      rdata_r <= 8'h00;
    else
      rdata_r <= REG_REQ.rd ? rd_mux : 8'h00;
  end

  // Outputs straight from flip-flops
  assign REG_RDATA = rdata_r;
  assign CHAN_A_WAVE_OUT = wave_a_r;
  assign CHAN_B_WAVE_OUT = wave_b_r;
  assign CHAN_A_OVERRIDE = ovr_a_r;
  assign CHAN_B_OVERRIDE = ovr_b_r;
  assign FLAGS = flags_r;
  assign COUNT_VALUE = count_r;

endmodule // t8woc_top

// ### testbench/t8woc_chk.sv
// Purpose: Port assertions for the timer waveform output control
// Assumes: Sees only the ports of t8woc_top
// Notes: Mirrors control and compare writes to form expectations
`timescale 1ns/1ns
`include "t8woc_regs.svh"
module t8woc_chk
  import t8woc_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire t8woc_req_t REG_REQ,
  input wire logic [7:0] REG_RDATA,
  input wire logic TICK_EN,
  input wire logic ACK_OVF,
  input wire logic ACK_A,
  input wire logic ACK_B,
  input wire logic CHAN_A_WAVE_OUT,
  input wire logic CHAN_A_OVERRIDE,
  input wire logic CHAN_B_WAVE_OUT,
  input wire logic CHAN_B_OVERRIDE,
  input wire t8woc_flags_t FLAGS,
  input wire logic [7:0] COUNT_VALUE
);
  // Mirrors of what software wrote
  logic [7:0] ctl_r;
  logic hb_r;
  logic [7:0] cmp_r;
  logic cmp_ok_r;
  logic blk_r;
  wire wr = REG_REQ.wr;
  wire [7:0] ad = REG_REQ.addr;
  wire rd_ctl = REG_REQ.rd && ad == `T8WOC_OFS_CTRL_A;
  wire [2:0] wgm = {hb_r, ctl_r[1:0]};
  wire rsvd = hb_r && !ctl_r[0];
  wire pwm = ctl_r[0];
  wire ovr_a = ctl_r[7:6] != 2'h0 && !rsvd && !(ctl_r[7:6] == 2'h1 && pwm && !hb_r);
  wire ovr_b = ctl_r[5:4] != 2'h0 && !rsvd && !(ctl_r[5:4] == 2'h1 && pwm);
  wire run = TICK_EN && !wr;
  // Track writes; a counter write blocks the next tick's match
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      ctl_r <= 8'h00;
      hb_r <= 1'b0;
      cmp_r <= 8'h00;
      cmp_ok_r <= 1'b1;
      blk_r <= 1'b0;
    end
    else
    begin
      if (wr && ad == `T8WOC_OFS_CTRL_A)
        ctl_r <= REG_REQ.wdata & 8'hF3;
      if (wr && ad == `T8WOC_OFS_CTRL_B)
        hb_r <= REG_REQ.wdata[3];
      if (wr && ad == `T8WOC_OFS_CMP_A)
      begin
        cmp_r <= REG_REQ.wdata;
        cmp_ok_r <= wgm == 3'h0 || wgm == 3'h2;
      end
      if (wr && ad == `T8WOC_OFS_COUNT)
        blk_r <= 1'b1;
      else if (TICK_EN)
        blk_r <= 1'b0;
    end
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  AST_COUNT_HOLD:
    assert property (!TICK_EN && !wr |=> $stable(COUNT_VALUE)) else $error("count moved");
  AST_OVR_A:
    assert property (!$past(RST) |-> CHAN_A_OVERRIDE == $past(ovr_a)) else $error("ovr a");
  AST_OVR_B:
    assert property (!$past(RST) |-> CHAN_B_OVERRIDE == $past(ovr_b)) else $error("ovr b");
  AST_CTRL_READ:
    assert property ($past(rd_ctl) |-> REG_RDATA == $past(ctl_r)) else $error("ctrl read");
  AST_MAX_OVF:
    assert property (run && COUNT_VALUE == 8'hFF && (wgm == 3'h0 || wgm == 3'h3)
      |=> FLAGS.ovf && COUNT_VALUE == 8'h00) else $error("ovf at max");
  AST_CTC_CLEAR:
    assert property (run && !blk_r && cmp_ok_r && wgm == 3'h2 && COUNT_VALUE == cmp_r
      |=> COUNT_VALUE == 8'h00 && FLAGS.match_a) else $error("ctc clear");
  AST_ACK_CLR:
    assert property (ACK_OVF && !TICK_EN |=> !FLAGS.ovf) else $error("ack clear");
  AST_PHASE_TURN:
    assert property (run && wgm == 3'h1 && COUNT_VALUE == 8'hFF |=> COUNT_VALUE == 8'hFE)
      else $error("phase turn");
  AST_FLAG_ON_TICK:
    assert property ($rose(FLAGS.ovf) || $rose(FLAGS.match_a) || $rose(FLAGS.match_b)
      |-> $past(TICK_EN)) else $error("flag off tick");
  // Main scenarios reached
  cover property (wgm == 3'h1 && TICK_EN && COUNT_VALUE == 8'hFF);
  cover property ($rose(FLAGS.match_b));
  cover property (CHAN_A_OVERRIDE && CHAN_B_OVERRIDE);
endmodule // t8woc_chk

bind t8woc_top t8woc_chk t8woc_chk_i (.SYS_CLK(SYS_CLK), .RST(RST), .REG_REQ(REG_REQ),
  .REG_RDATA(REG_RDATA), .TICK_EN(TICK_EN), .ACK_OVF(ACK_OVF), .ACK_A(ACK_A), .ACK_B(ACK_B),
  .CHAN_A_WAVE_OUT(CHAN_A_WAVE_OUT), .CHAN_A_OVERRIDE(CHAN_A_OVERRIDE),
  .CHAN_B_WAVE_OUT(CHAN_B_WAVE_OUT), .CHAN_B_OVERRIDE(CHAN_B_OVERRIDE), .FLAGS(FLAGS),
  .COUNT_VALUE(COUNT_VALUE));

// ### testbench/t8woc_pin_model.sv
// Purpose: Port pin fed by one waveform output
// Assumes: Pull-up holds the pin high when undriven
// Notes: Direction and port value come from software
`timescale 1ns/1ns
module t8woc_pin_model
(
  input wire logic wave,
  input wire logic ovr,
  input wire logic dir_out,
  input wire logic port_val,
  output logic pin
);
  assign pin = dir_out ? (ovr ? wave : port_val) : 1'b1;
endmodule // t8woc_pin_model

// ### testbench/t8woc_tb.sv
// Purpose: Directed register and tick sequences for the timer
// Assumes: 25 MHz clock, synchronous reset
// Notes: Expectations follow the mode tables
`timescale 1ns/1ns
`define TB_CHK(nm, ex, got) \
  begin n_tests++; if ((got) !== (ex)) begin failures++; \
  $display("ERROR %s exp %0h got %0h", nm, ex, got); end end
module t8woc_tb
  import t8woc_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  t8woc_req_t req = '0;
  logic tick_en = 1'b0;
  logic ack_ovf = 1'b0;
  logic ack_a = 1'b0;
  logic ack_b = 1'b0;
  // Port direction of pin A, set to output by software
  logic dir_a = 1'b0;
  logic [7:0] rdata;
  logic wave_a, ovr_a, wave_b, ovr_b, pin_a, pin_b;
  t8woc_flags_t flags;
  logic [7:0] count;
  logic [7:0] ofs [7] = '{8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h35, 8'h30};
  int failures = 0;
  int n_tests = 0;
  always #20 sys_clk = ~sys_clk;
  t8woc_top t8woc_top_i (.SYS_CLK(sys_clk), .RST(rst), .REG_REQ(req), .REG_RDATA(rdata),
    .TICK_EN(tick_en), .ACK_OVF(ack_ovf), .ACK_A(ack_a), .ACK_B(ack_b),
    .CHAN_A_WAVE_OUT(wave_a), .CHAN_A_OVERRIDE(ovr_a), .CHAN_B_WAVE_OUT(wave_b),
    .CHAN_B_OVERRIDE(ovr_b), .FLAGS(flags), .COUNT_VALUE(count));
  t8woc_pin_model pin_a_i (.wave(wave_a), .ovr(ovr_a), .dir_out(dir_a), .port_val(1'b0),
    .pin(pin_a));
  t8woc_pin_model pin_b_i (.wave(wave_b), .ovr(ovr_b), .dir_out(1'b1), .port_val(1'b0),
    .pin(pin_b));
  // One write cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge sys_clk);
    req.wr <= 1'b0;
  endtask
  // One read cycle, data compared in the next
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] ex);
    @(posedge sys_clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge sys_clk);
    req.rd <= 1'b0;
    @(negedge sys_clk);
    `TB_CHK("rdata", ex, rdata)
  endtask
  // A run of n consecutive ticks
  task automatic ticks(input int n);
    @(posedge sys_clk);
    tick_en <= 1'b1;
    repeat (n) @(posedge sys_clk);
    tick_en <= 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic end_sim();
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    failures++;
    end_sim();
  end
  initial
  begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    foreach (ofs[i]) rd_chk(ofs[i], 8'h00);
    `TB_CHK("pin_a", 1'b1, pin_a)
    dir_a <= 1'b1;
    wr(8'h24, 8'hFF);
    rd_chk(8'h24, 8'hF3);
    wr(8'h27, 8'h05);
    wr(8'h28, 8'h05);
    // Toggle, clear, set in normal mode
    for (int i = 1; i < 4; i++)
    begin
      wr(8'h24, {i[1:0], i[1:0], 4'h0});
      wr(8'h26, 8'h04);
      ticks(2);
      `TB_CHK("wave_a", i[0], wave_a)
      `TB_CHK("wave_b", i[0], wave_b)
      `TB_CHK("ovr_a", 1'b1, ovr_a)
      `TB_CHK("match_b", 1'b1, flags.match_b)
    end
    `TB_CHK("pin_a", 1'b1, pin_a)
    wr(8'h26, 8'hFF);
    ticks(1);
    `TB_CHK("count", 8'h00, count)
    `TB_CHK("ovf", 1'b1, flags.ovf)
    @(posedge sys_clk);
    ack_ovf <= 1'b1;
    ack_b <= 1'b1;
    @(posedge sys_clk);
    ack_ovf <= 1'b0;
    ack_b <= 1'b0;
    @(negedge sys_clk);
    `TB_CHK("ovf", 1'b0, flags.ovf)
    `TB_CHK("match_b", 1'b0, flags.match_b)
    wr(8'h35, 8'h06);
    rd_chk(8'h35, 8'h00);
    // Fast PWM, buffered compare
    wr(8'h24, 8'hA3);
    wr(8'h27, 8'h10);
    wr(8'h28, 8'h10);
    wr(8'h26, 8'h04);
    ticks(2);
    `TB_CHK("wave_a", 1'b0, wave_a)
    wr(8'h26, 8'hFE);
    ticks(2);
    `TB_CHK("count", 8'h00, count)
    `TB_CHK("wave_a", 1'b1, wave_a)
    `TB_CHK("wave_b", 1'b1, wave_b)
    wr(8'h26, 8'h0E);
    ticks(3);
    `TB_CHK("wave_a", 1'b0, wave_a)
    `TB_CHK("wave_b", 1'b0, wave_b)
    wr(8'h24, 8'h93);
    rd_chk(8'h24, 8'h93);
    `TB_CHK("ovr_b", 1'b0, ovr_b)
    `TB_CHK("ovr_a", 1'b1, ovr_a)
    // Phase correct PWM
    wr(8'h24, 8'hB1);
    wr(8'h26, 8'h0E);
    ticks(3);
    `TB_CHK("wave_a", 1'b0, wave_a)
    `TB_CHK("wave_b", 1'b1, wave_b)
    wr(8'h26, 8'hFE);
    ticks(2);
    `TB_CHK("count", 8'hFE, count)
    ticks(239);
    `TB_CHK("wave_a", 1'b1, wave_a)
    `TB_CHK("wave_b", 1'b0, wave_b)
    `TB_CHK("count", 8'h0F, count)
    wr(8'h35, 8'h07);
    ticks(16);
    `TB_CHK("ovf", 1'b1, flags.ovf)
    `TB_CHK("count", 8'h01, count)
    // Clear on compare A match
    wr(8'h24, 8'h02);
    wr(8'h27, 8'h08);
    wr(8'h26, 8'h06);
    ticks(3);
    `TB_CHK("count", 8'h00, count)
    `TB_CHK("match_a", 1'b1, flags.match_a)
    `TB_CHK("pin_a", 1'b0, pin_a)
    // Acknowledge clears compare flag A
    @(posedge sys_clk);
    ack_a <= 1'b1;
    @(posedge sys_clk);
    ack_a <= 1'b0;
    @(negedge sys_clk);
    `TB_CHK("match_a", 1'b0, flags.match_a)
    // Fast PWM with compare A as TOP, channel A toggles
    wr(8'h35, 8'h07);
    wr(8'h25, 8'h08);
    wr(8'h24, 8'h53);
    wr(8'h26, 8'h06);
    ticks(3);
    `TB_CHK("wave_a", 1'b0, wave_a)
    `TB_CHK("count", 8'h00, count)
    `TB_CHK("match_a", 1'b1, flags.match_a)
    `TB_CHK("ovf", 1'b1, flags.ovf)
    `TB_CHK("ovr_a", 1'b1, ovr_a)
    `TB_CHK("ovr_b", 1'b0, ovr_b)
    rd_chk(8'h25, 8'h08);
    // Compare A equal to TOP: bottom action only
    wr(8'h24, 8'hA3);
    wr(8'h26, 8'h06);
    ticks(3);
    `TB_CHK("wave_a", 1'b1, wave_a)
    `TB_CHK("wave_b", 1'b1, wave_b)
    // Reserved mode: outputs off, normal count
    wr(8'h24, 8'hF0);
    wr(8'h26, 8'hFF);
    ticks(1);
    `TB_CHK("ovr_a", 1'b0, ovr_a)
    `TB_CHK("ovr_b", 1'b0, ovr_b)
    `TB_CHK("count", 8'h00, count)
    end_sim();
  end
endmodule // t8woc_tb
